//--- crq_payload.sv
// payload byte and length lookup for each answered group
`timescale 1ns/100ps
module crq_payload (
    // selection
    input crq_pkg::crq_grp_t grp,
    input wire logic [6:0] idx,
    // stored content
    input wire logic [127:0][7:0] ident,
    input wire logic [15:0] lamp1,
    input wire logic [15:0] lamp2,
    input wire logic [3:0][31:0] dtc1,
    input wire logic [3:0][31:0] dtc2,
    input wire logic [2:0] cnt1,
    input wire logic [2:0] cnt2,
    input wire logic [63:0] name,
    // result
    output logic [7:0] pbyte,
    output logic [6:0] plen
);
    wire dm2 = (grp == crq_pkg::GRP_DM2);
    wire [15:0] lamp = dm2 ? lamp2 : lamp1;
    wire [3:0][31:0] dtc = dm2 ? dtc2 : dtc1;
    wire [2:0] cnt = dm2 ? cnt2 : cnt1;
    wire [6:0] dm_rel = idx - crq_pkg::DM_HDR_LEN;
    wire [4:0] slot = dm_rel[6:2];
    // slots beyond the stored count are padded, as is the short frame
    wire [7:0] dtc_byte = dtc[slot[1:0]][{dm_rel[1:0], 3'b000} +: 8];
    wire [7:0] dm_byte = (idx == 7'h00) ? lamp[7:0] :
        (idx == 7'h01) ? lamp[15:8] :
        (slot < {2'b00, cnt}) ? dtc_byte : crq_pkg::DM_PAD;
    wire [6:0] dm_raw = 7'({cnt, 2'b00}) + crq_pkg::DM_HDR_LEN;
    wire [6:0] dm_len = (dm_raw < crq_pkg::DM_MIN_LEN) ? crq_pkg::DM_MIN_LEN : dm_raw;
    // soft fields sit in ident 0..63 so that the delimiter falls on every 16th byte
    wire [7:0] soft_byte = (idx == 7'h00) ? crq_pkg::SOFT_COUNT :
        (idx[3:0] == 4'h0) ? crq_pkg::DELIM : ident[idx - 7'h01];
    wire ecu_delim = (idx == crq_pkg::ECU_DELIM0) || (idx == crq_pkg::ECU_DELIM1) ||
        (idx == crq_pkg::ECU_DELIM2);
    wire [6:0] ecu_addr = (idx < crq_pkg::ECU_SERIAL_END) ? idx + crq_pkg::ECU_MEM_BASE :
        (idx < crq_pkg::ECU_DELIM1) ? idx + crq_pkg::ECU_MEM_BASE - 7'h01 :
        idx + crq_pkg::ECU_MEM_BASE - 7'h02;
    wire [7:0] ecu_byte = ecu_delim ? crq_pkg::DELIM : ident[ecu_addr];
    wire [7:0] claim_byte = name[{idx[2:0], 3'b000} +: 8];

    always_comb begin
        pbyte = 8'h00;
        plen = 7'h00;
        case (grp)
            crq_pkg::GRP_CLAIM: begin
                pbyte = claim_byte;
                plen = crq_pkg::CLAIM_LEN;
            end
            crq_pkg::GRP_SOFT: begin
                pbyte = soft_byte;
                plen = crq_pkg::SOFT_LEN;
            end
            crq_pkg::GRP_ECU: begin
                pbyte = ecu_byte;
                plen = crq_pkg::ECU_LEN;
            end
            crq_pkg::GRP_DM1, crq_pkg::GRP_DM2: begin
                pbyte = dm_byte;
                plen = dm_len;
            end
            default: begin
                pbyte = 8'h00;
                plen = 7'h00;
            end
        endcase
    end
endmodule : crq_payload

//--- crq_peer.sv
// far-side node model: sends request frames and takes payload bytes
`timescale 1ns/100ps
module crq_peer (
    // clock and pacing
    input wire logic MCLK,
    input wire logic slow,
    // frames to the device
    output logic RX_VALID,
    output crq_pkg::crq_rx_t RX_FRAME,
    // stream acceptance
    output logic TX_READY
);
    initial begin
        RX_VALID = 1'b0;
        RX_FRAME = '0;
        TX_READY = 1'b0;
    end
    // a slow consumer stalls every other cycle
    always @(posedge MCLK) TX_READY <= slow ? ~TX_READY : 1'b1;
    // priority 6, both page bits clear, sender address 0x21
    task automatic send(input logic [7:0] ps, input logic [23:0] pgn, input logic [3:0] dlc);
        // pacing is only advised, so the bench may send frames close together
        @(posedge MCLK);
        RX_VALID <= 1'b1;
        RX_FRAME <= '{id: {3'h6, 2'h0, 8'hEA, ps, 8'h21}, dlc: dlc, data: pgn};
        // group number goes low byte first in the three payload bytes
        @(posedge MCLK);
        RX_VALID <= 1'b0;
        // a stale frame must not look valid, so the lines change once released
        RX_FRAME <= ~RX_FRAME;
    endtask : send
endmodule : crq_peer

//--- crq_pkg.sv
// constants, types and register map of the request responder
package crq_pkg;
    // request frame recognition
    localparam logic [23:0] REQ_PGN = 24'h00EA00;
    localparam logic [7:0] REQ_PF = 8'hEA;
    localparam logic [3:0] REQ_DLC = 4'h3;
    localparam logic [7:0] GLOBAL_DA = 8'hFF;
    // requestable groups
    localparam logic [23:0] PGN_CLAIM = 24'h00EE00;
    localparam logic [23:0] PGN_SOFT = 24'h00FEDA;
    localparam logic [23:0] PGN_ECU = 24'h00FDC5;
    localparam logic [23:0] PGN_DM1 = 24'h00FECA;
    localparam logic [23:0] PGN_DM2 = 24'h00FECB;
    localparam logic [23:0] PGN_DM3 = 24'h00FECC;
    localparam logic [23:0] PGN_DM11 = 24'h00FED3;
    // acknowledgement control codes
    localparam logic [7:0] ACK_POS = 8'h00;
    localparam logic [7:0] ACK_NEG = 8'h01;
    localparam logic [7:0] ACK_DENIED = 8'h02;
    localparam logic [7:0] ACK_BUSY = 8'h03;
    // payload layouts
    localparam logic [7:0] SOFT_COUNT = 8'h04;
    localparam logic [7:0] DELIM = 8'h2A;
    localparam logic [6:0] SOFT_LEN = 7'h41;
    localparam logic [6:0] ECU_LEN = 7'h22;
    localparam logic [6:0] ECU_SERIAL_END = 7'h10;
    localparam logic [6:0] ECU_DELIM0 = 7'h10;
    localparam logic [6:0] ECU_DELIM1 = 7'h1F;
    localparam logic [6:0] ECU_DELIM2 = 7'h21;
    localparam logic [6:0] ECU_MEM_BASE = 7'h40;
    localparam logic [6:0] CLAIM_LEN = 7'h08;
    localparam logic [6:0] DM_HDR_LEN = 7'h02;
    localparam logic [6:0] DM_MIN_LEN = 7'h08;
    localparam logic [7:0] DM_PAD = 8'hFF;
    localparam logic [6:0] SINGLE_MAX = 7'h08;
    localparam int LAMP_COUNT = 4;
    localparam int LAMP_W = 2;
    localparam int FLASH_BASE = 8;
    localparam int DTC_SLOTS = 4;
    localparam logic [2:0] DTC_MAX = 3'h4;
    localparam logic [1:0] LAMP_OFF = 2'h0;
    localparam logic [1:0] LAMP_ON = 2'h1;
    localparam logic [1:0] FLASH_SLOW = 2'h0;
    localparam logic [1:0] FLASH_FAST = 2'h1;
    localparam logic [1:0] FLASH_RSVD = 2'h2;
    localparam logic [1:0] FLASH_NONE = 2'h3;
    // register map, byte addresses
    localparam logic [9:0] REG_CTRL = 10'h000;
    localparam logic [9:0] REG_STAT = 10'h004;
    localparam logic [9:0] REG_LAMP1 = 10'h008;
    localparam logic [9:0] REG_LAMP2 = 10'h00C;
    localparam logic [9:0] REG_DTCCNT = 10'h010;
    localparam logic [9:0] REG_NAME_LO = 10'h018;
    localparam logic [9:0] REG_NAME_HI = 10'h01C;
    localparam logic [9:0] REG_DTC1 = 10'h020;
    localparam logic [9:0] REG_DTC2 = 10'h030;
    localparam logic [9:0] REG_IDENT = 10'h200;
    // reset values
    localparam logic [7:0] OWN_ADDR_RST = 8'h80;
    localparam logic [15:0] LAMP_RST = 16'hFF00;
    localparam logic [63:0] NAME_RST = 64'h0;

    typedef enum logic [2:0] {
        GRP_NONE, GRP_CLAIM, GRP_SOFT, GRP_ECU, GRP_DM1, GRP_DM2, GRP_DM3, GRP_DM11
    } crq_grp_t;

    typedef struct packed {
        logic [28:0] id;
        logic [3:0] dlc;
        logic [23:0] data;
    } crq_rx_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [23:0] pgn;
        logic [7:0] da;
    } crq_ack_t;

    typedef struct packed {
        logic [23:0] pgn;
        logic [7:0] da;
        logic [6:0] len;
        logic bam;
        logic [6:0] idx;
        logic [7:0] data;
        logic last;
    } crq_tx_t;
endpackage : crq_pkg

//--- crq_responder.sv
// request decoder, acknowledgement and payload streamer with its registers
`timescale 1ns/100ps
module crq_responder (
    // clock, reset, enable
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic CE,
    // register port
    input wire logic [9:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // received frames and transport busy
    input wire logic RX_VALID,
    input crq_pkg::crq_rx_t RX_FRAME,
    input wire logic TP_BUSY,
    // acknowledgement out
    output logic ACK_VALID,
    output crq_pkg::crq_ack_t ACK,
    // payload stream to the transport engine
    output logic TX_VALID,
    output crq_pkg::crq_tx_t TX,
    input wire logic TX_READY,
    // diagnostic clear pulses
    output logic CLR_ACTIVE,
    output logic CLR_PREV
);
    typedef enum logic {ST_IDLE, ST_SEND} crq_st_t;

    crq_st_t st_q;
    logic [7:0] own_addr_q;
    logic enable_q;
    logic [15:0] lamp1_q, lamp2_q;
    logic [2:0] cnt1_q, cnt2_q;
    logic [63:0] name_q;
    logic [3:0][31:0] dtc1_q, dtc2_q;
    logic [127:0][7:0] ident_q;
    logic [7:0] served_q;
    logic [7:0] last_ack_q;
    logic [31:0] rdata_q;
    logic ack_valid_q, tx_valid_q, clr_act_q, clr_prev_q;
    crq_pkg::crq_ack_t ack_q;
    crq_pkg::crq_tx_t tx_q;
    crq_pkg::crq_grp_t grp_q;

    // reserved flash code would read as a flashing lamp; force it to unavailable
    function automatic logic [15:0] clean_lamp(input logic [15:0] w);
        logic [15:0] r;
        r = w;
        for (int i = 0; i < crq_pkg::LAMP_COUNT; i++) begin
            if (w[crq_pkg::FLASH_BASE + crq_pkg::LAMP_W * i +: 2] == crq_pkg::FLASH_RSVD) begin
                r[crq_pkg::FLASH_BASE + crq_pkg::LAMP_W * i +: 2] = crq_pkg::FLASH_NONE;
            end
        end
        return r;
    endfunction : clean_lamp

    function automatic logic [2:0] clamp_cnt(input logic [2:0] c);
        return (c > crq_pkg::DTC_MAX) ? crq_pkg::DTC_MAX : c;
    endfunction : clamp_cnt

    // frame decode
    wire [7:0] rx_pf = RX_FRAME.id[23:16];
    wire [7:0] rx_ps = RX_FRAME.id[15:8];
    wire [7:0] rx_sa = RX_FRAME.id[7:0];
    wire rx_pages_zero = (RX_FRAME.id[25:24] == 2'b00);
    wire [23:0] req_pgn = RX_FRAME.data;
    wire req_hit = RX_VALID && enable_q && (rx_pf == crq_pkg::REQ_PF) && rx_pages_zero &&
        (RX_FRAME.dlc == crq_pkg::REQ_DLC);
    wire is_glob = (rx_ps == crq_pkg::GLOBAL_DA);
    wire is_spec = (rx_ps == own_addr_q) && !is_glob;
    // anything outside the list, cyclic groups included, maps to none
    wire crq_pkg::crq_grp_t req_grp =
        (req_pgn == crq_pkg::PGN_CLAIM) ? crq_pkg::GRP_CLAIM :
        (req_pgn == crq_pkg::PGN_SOFT) ? crq_pkg::GRP_SOFT :
        (req_pgn == crq_pkg::PGN_ECU) ? crq_pkg::GRP_ECU :
        (req_pgn == crq_pkg::PGN_DM1) ? crq_pkg::GRP_DM1 :
        (req_pgn == crq_pkg::PGN_DM2) ? crq_pkg::GRP_DM2 :
        (req_pgn == crq_pkg::PGN_DM3) ? crq_pkg::GRP_DM3 :
        (req_pgn == crq_pkg::PGN_DM11) ? crq_pkg::GRP_DM11 : crq_pkg::GRP_NONE;
    wire supp = (req_grp != crq_pkg::GRP_NONE);
    // frames that arrive while a payload is streaming are dropped
    wire take = CE && (st_q == ST_IDLE) && req_hit && (is_glob || is_spec);

    // payload lookup: first byte at take, next byte on each accepted one
    wire tx_accept = tx_valid_q && TX_READY;
    wire crq_pkg::crq_grp_t pl_grp = (st_q == ST_IDLE) ? req_grp : grp_q;
    wire [6:0] pl_idx = (st_q == ST_IDLE) ? 7'h00 : tx_q.idx + 7'h01;
    wire [7:0] pl_byte;
    wire [6:0] pl_len;
    wire is_long = (pl_len > crq_pkg::SINGLE_MAX);
    wire blocked = is_long && TP_BUSY;
    wire pass = supp && !blocked;
    wire [7:0] ack_code = !supp ? crq_pkg::ACK_NEG :
        blocked ? crq_pkg::ACK_BUSY : crq_pkg::ACK_POS;

    crq_payload u_payload (
        .grp(pl_grp),
        .idx(pl_idx),
        .ident(ident_q),
        .lamp1(lamp1_q),
        .lamp2(lamp2_q),
        .dtc1(dtc1_q),
        .dtc2(dtc2_q),
        .cnt1(cnt1_q),
        .cnt2(cnt2_q),
        .name(name_q),
        .pbyte(pl_byte),
        .plen(pl_len)
    );

    // register decode
    wire wr_en = CE && WR;
    wire wr_ctrl = wr_en && (ADDR == crq_pkg::REG_CTRL);
    wire wr_lamp1 = wr_en && (ADDR == crq_pkg::REG_LAMP1);
    wire wr_lamp2 = wr_en && (ADDR == crq_pkg::REG_LAMP2);
    wire wr_cnt = wr_en && (ADDR == crq_pkg::REG_DTCCNT);
    wire wr_nlo = wr_en && (ADDR == crq_pkg::REG_NAME_LO);
    wire wr_nhi = wr_en && (ADDR == crq_pkg::REG_NAME_HI);
    wire wr_dtc1 = wr_en && (ADDR[9:4] == crq_pkg::REG_DTC1[9:4]);
    wire wr_dtc2 = wr_en && (ADDR[9:4] == crq_pkg::REG_DTC2[9:4]);
    wire wr_ident = wr_en && (ADDR[9] == crq_pkg::REG_IDENT[9]);
    wire [31:0] rd_mux =
        (ADDR == crq_pkg::REG_CTRL) ? {23'h0, enable_q, own_addr_q} :
        (ADDR == crq_pkg::REG_STAT) ? {8'h0, served_q, last_ack_q, 6'h0, TP_BUSY,
            (st_q == ST_SEND)} :
        (ADDR == crq_pkg::REG_LAMP1) ? {16'h0, lamp1_q} :
        (ADDR == crq_pkg::REG_LAMP2) ? {16'h0, lamp2_q} :
        (ADDR == crq_pkg::REG_DTCCNT) ? {25'h0, cnt2_q, 1'b0, cnt1_q} :
        (ADDR == crq_pkg::REG_NAME_LO) ? name_q[31:0] :
        (ADDR == crq_pkg::REG_NAME_HI) ? name_q[63:32] :
        (ADDR[9:4] == crq_pkg::REG_DTC1[9:4]) ? dtc1_q[ADDR[3:2]] :
        (ADDR[9:4] == crq_pkg::REG_DTC2[9:4]) ? dtc2_q[ADDR[3:2]] :
        (ADDR[9] == crq_pkg::REG_IDENT[9]) ? {24'h0, ident_q[ADDR[8:2]]} : 32'h0;

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            own_addr_q <= crq_pkg::OWN_ADDR_RST;
            enable_q <= 1'b1;
            lamp1_q <= crq_pkg::LAMP_RST;
            lamp2_q <= crq_pkg::LAMP_RST;
            cnt1_q <= 3'h0;
            cnt2_q <= 3'h0;
            name_q <= crq_pkg::NAME_RST;
            rdata_q <= 32'h0;
        end else if (CE) begin
            if (wr_ctrl) begin
                own_addr_q <= WDATA[7:0];
                enable_q <= WDATA[8];
            end
            if (wr_lamp1) lamp1_q <= clean_lamp(WDATA[15:0]);
            if (wr_lamp2) lamp2_q <= clean_lamp(WDATA[15:0]);
            if (wr_cnt) begin
                cnt1_q <= clamp_cnt(WDATA[2:0]);
                cnt2_q <= clamp_cnt(WDATA[6:4]);
            end
            if (wr_nlo) name_q[31:0] <= WDATA;
            if (wr_nhi) name_q[63:32] <= WDATA;
            rdata_q <= RD ? rd_mux : 32'h0;
        end
    end

    for (genvar g = 0; g < crq_pkg::DTC_SLOTS; g++) begin : g_dtc
        always_ff @(posedge MCLK) begin
            if (!RSTN) begin
                dtc1_q[g] <= 32'h0;
                dtc2_q[g] <= 32'h0;
            end else if (CE && (ADDR[3:2] == 2'(g))) begin
                if (wr_dtc1) dtc1_q[g] <= WDATA;
                if (wr_dtc2) dtc2_q[g] <= WDATA;
            end
        end
    end

    for (genvar g = 0; g < 128; g++) begin : g_ident
        always_ff @(posedge MCLK) begin
            if (!RSTN) begin
                ident_q[g] <= 8'h00;
            end else if (wr_ident && (ADDR[8:2] == 7'(g))) begin
                ident_q[g] <= WDATA[7:0];
            end
        end
    end

    // acknowledgement and clear pulses
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            ack_valid_q <= 1'b0;
            ack_q <= '0;
            last_ack_q <= crq_pkg::ACK_POS;
            served_q <= 8'h00;
            clr_act_q <= 1'b0;
            clr_prev_q <= 1'b0;
        end else if (CE) begin
            ack_valid_q <= take && is_spec;
            clr_act_q <= take && pass && (req_grp == crq_pkg::GRP_DM11);
            clr_prev_q <= take && pass && (req_grp == crq_pkg::GRP_DM3);
            if (take && is_spec) begin
                ack_q <= '{ctrl: ack_code, pgn: req_pgn, da: rx_sa};
                last_ack_q <= ack_code;
            end
            if (take && pass) served_q <= served_q + 8'h01;
        end
    end

    // payload streamer; groups of zero length start no stream, a specific request gets the acknowledgement alone
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            st_q <= ST_IDLE;
            grp_q <= crq_pkg::GRP_NONE;
            tx_valid_q <= 1'b0;
            tx_q <= '0;
        end else if (CE) begin
            case (st_q)
                ST_IDLE: begin
                    if (take && pass && (pl_len != 7'h00)) begin
                        st_q <= ST_SEND;
                        grp_q <= req_grp;
                        tx_valid_q <= 1'b1;
                        tx_q <= '{pgn: req_pgn, da: is_spec ? rx_sa : crq_pkg::GLOBAL_DA,
                            len: pl_len, bam: is_long, idx: 7'h00, data: pl_byte,
                            last: (pl_len == 7'h01)};
                    end
                end
                ST_SEND: begin
                    if (tx_accept && tx_q.last) begin
                        st_q <= ST_IDLE;
                        tx_valid_q <= 1'b0;
                    end else if (tx_accept) begin
                        tx_q.idx <= pl_idx;
                        tx_q.data <= pl_byte;
                        tx_q.last <= (pl_idx == tx_q.len - 7'h01);
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    tx_valid_q <= 1'b0;
                end
            endcase
        end
    end

    assign RDATA = rdata_q;
    assign ACK_VALID = ack_valid_q;
    assign ACK = ack_q;
    assign TX_VALID = tx_valid_q;
    assign TX = tx_q;
    assign CLR_ACTIVE = clr_act_q;
    assign CLR_PREV = clr_prev_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    sequence s_take_spec;
        take && is_spec;
    endsequence
    sequence s_take_glob;
        take && is_glob;
    endsequence

    property p_no_denied;
        ACK_VALID |-> ACK.ctrl != crq_pkg::ACK_DENIED;
    endproperty
    a_no_denied: assert property (p_no_denied) else $error("access denied code sent");

    property p_nack;
        s_take_spec ##0 !supp |=> ACK_VALID && ACK.ctrl == crq_pkg::ACK_NEG && !TX_VALID;
    endproperty
    a_nack: assert property (p_nack) else $error("unknown group not refused");

    property p_pos;
        s_take_spec ##0 pass |=> ACK_VALID && ACK.ctrl == crq_pkg::ACK_POS &&
            ACK.pgn == $past(req_pgn);
    endproperty
    a_pos: assert property (p_pos) else $error("served request not acknowledged");

    property p_busy;
        s_take_spec ##0 (supp && blocked) |=> ACK_VALID && ACK.ctrl == crq_pkg::ACK_BUSY &&
            st_q == ST_IDLE;
    endproperty
    a_busy: assert property (p_busy) else $error("busy transport not reported");

    property p_glob_ignore;
        s_take_glob ##0 !supp |=> !ACK_VALID && !TX_VALID;
    endproperty
    a_glob_ignore: assert property (p_glob_ignore) else $error("global unknown answered");

    property p_recognise;
        $rose(ACK_VALID) |-> $past(rx_pf) == crq_pkg::REQ_PF && $past(rx_pages_zero);
    endproperty
    a_recognise: assert property (p_recognise) else $error("ack without request frame");

    property p_pgn_order;
        take && pass && supp && pl_len != 7'h00 |=> TX_VALID && TX.pgn == $past(RX_FRAME.data)
            && TX.idx == 7'h00;
    endproperty
    a_pgn_order: assert property (p_pgn_order) else $error("wrong group answered");

    property p_soft_head;
        TX_VALID && grp_q == crq_pkg::GRP_SOFT && TX.idx == 7'h00 |->
            TX.data == crq_pkg::SOFT_COUNT && TX.len == crq_pkg::SOFT_LEN && TX.bam;
    endproperty
    a_soft_head: assert property (p_soft_head) else $error("soft ident header wrong");

    property p_soft_delim;
        TX_VALID && grp_q == crq_pkg::GRP_SOFT && TX.idx != 7'h00 && TX.idx[3:0] == 4'h0 |->
            TX.data == crq_pkg::DELIM;
    endproperty
    a_soft_delim: assert property (p_soft_delim) else $error("soft delimiter missing");

    property p_bam;
        TX_VALID |-> TX.bam == (TX.len > crq_pkg::SINGLE_MAX);
    endproperty
    a_bam: assert property (p_bam) else $error("transport choice wrong");

    property p_hold;
        CE && TX_VALID && !TX_READY |=> TX_VALID && $stable(TX);
    endproperty
    a_hold: assert property (p_hold) else $error("stream byte dropped");
endmodule : crq_responder

//--- test_crq_responder.sv
// self-checking bench for the request responder
`timescale 1ns/100ps
module test_crq_responder;
    logic MCLK, RSTN, CE, WR, RD, TP_BUSY, ACK_VALID, TX_VALID, TX_READY, CLR_ACTIVE, CLR_PREV;
    logic RX_VALID, slow;
    logic [9:0] ADDR;
    logic [31:0] WDATA, RDATA;
    crq_pkg::crq_rx_t RX_FRAME;
    crq_pkg::crq_ack_t ACK;
    crq_pkg::crq_tx_t TX;
    logic [7:0] got [0:127];
    logic [6:0] lst;
    int failures, checked, ngot, cyc;
    crq_responder dut_u (.MCLK(MCLK), .RSTN(RSTN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME), .TP_BUSY(TP_BUSY),
        .ACK_VALID(ACK_VALID), .ACK(ACK), .TX_VALID(TX_VALID), .TX(TX), .TX_READY(TX_READY),
        .CLR_ACTIVE(CLR_ACTIVE), .CLR_PREV(CLR_PREV));
    crq_peer peer_u (.MCLK(MCLK), .slow(slow), .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME),
        .TX_READY(TX_READY));
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    always @(posedge MCLK) if (TX_VALID && TX_READY) begin
        got[TX.idx] <= TX.data;
        ngot <= ngot + 1;
        if (TX.last) lst <= TX.idx;
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge MCLK);
        {ADDR, WDATA, WR} <= {a, d, 1'b1};
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge MCLK);
        {ADDR, RD} <= {a, 1'b1};
        @(posedge MCLK);
        RD <= 1'b0;
        #1 check(RDATA, exp);
    endtask : rd
    function automatic logic [7:0] idv(input int i);
        return 8'(i * 7 + 3);
    endfunction : idv
    // k: 0 soft, 1 ecu, 2 dm1, 3 dm2, 4 claim
    function automatic logic [7:0] ex(input int k, input int i);
        case (k)
            0: return i == 0 ? 8'h04 : i % 16 == 0 ? 8'h2A : idv(i - 1);
            1: return i == 16 || i == 31 || i == 33 ? 8'h2A : i < 16 ? idv(64 + i)
                : i < 31 ? idv(63 + i) : idv(94);
            2: return i == 0 ? 8'h11 : i == 1 ? 8'hF4 : i < 6 ? 8'(32'h11223344 >> 8 * (i - 2))
                : 8'hFF;
            3: return i == 0 ? 8'h00 : i == 1 ? 8'hFF
                : 8'((32'hC0DE0000 + (i - 2) / 4) >> 8 * ((i - 2) % 4));
            default: return 8'(64'h0123456789ABCDEF >> 8 * i);
        endcase
    endfunction : ex
    // one request; ack 9'h100 means no ack expected, n bytes of kind k expected
    task automatic serve(input logic [7:0] ps, input logic [23:0] pgn, input logic [3:0] dlc,
        input int k, input logic [6:0] n, input logic [8:0] ack);
        int n0;
        n0 = ngot;
        peer_u.send(ps, pgn, dlc);
        #1;
        if (ack[8]) check(ACK_VALID, 0);
        else check({ACK_VALID, ACK.ctrl, ACK.pgn, ACK.da}, {1'b1, ack[7:0], pgn, 8'h21});
        if (n != 0) check({TX_VALID, TX.bam, TX.len, TX.da, TX.pgn}, {1'b1, n > 8, n,
            ps == 8'hFF ? 8'hFF : 8'h21, pgn});
        for (int w = 0; w < 400 && ngot - n0 < n; w++) begin
            @(posedge MCLK);
            #1;
        end
        repeat (3) @(posedge MCLK);
        #1 check(ngot - n0, n);
        check(TX_VALID, 0);
        if (n != 0) check(lst, n - 1);
        for (int i = 0; i < n; i++) check(got[i], ex(k, i));
    endtask : serve
    initial begin
        {RSTN, CE, WR, RD, TP_BUSY, slow, ADDR, WDATA, failures, checked, ngot, cyc} = '0;
        repeat (6) @(posedge MCLK);
        RSTN <= 1'b1;
        CE <= 1'b1;
        rd(crq_pkg::REG_CTRL, 32'h180);
        rd(crq_pkg::REG_LAMP1, 32'hFF00);
        rd(10'h014, 32'h0);
        for (int i = 0; i < 128; i++) wr(crq_pkg::REG_IDENT + 10'(4 * i), idv(i));
        wr(crq_pkg::REG_NAME_LO, 32'h89ABCDEF);
        wr(crq_pkg::REG_NAME_HI, 32'h01234567);
        wr(crq_pkg::REG_LAMP1, 32'hB411);
        wr(crq_pkg::REG_DTCCNT, 32'h47);
        rd(crq_pkg::REG_DTCCNT, 32'h44);
        wr(crq_pkg::REG_DTCCNT, 32'h41);
        wr(crq_pkg::REG_DTC1, 32'h11223344);
        for (int j = 0; j < 4; j++) wr(crq_pkg::REG_DTC2 + 10'(4 * j), 32'hC0DE0000 + j);
        @(posedge MCLK) slow <= 1'b1;
        serve(8'h80, 24'h00FEDA, 4'h3, 0, 65, 9'h000);
        serve(8'hFF, 24'h00FDC5, 4'h3, 1, 34, 9'h100);
        @(posedge MCLK) slow <= 1'b0;
        serve(8'h80, 24'h00FECA, 4'h3, 2, 8, 9'h000);
        serve(8'h80, 24'h00FECB, 4'h3, 3, 18, 9'h000);
        serve(8'hFF, 24'h00EE00, 4'h3, 4, 8, 9'h100);
        serve(8'h80, 24'h123456, 4'h3, 0, 0, 9'h001);
        serve(8'hFF, 24'h123456, 4'h3, 0, 0, 9'h100);
        serve(8'h80, 24'h00FF2A, 4'h3, 0, 0, 9'h001);
        serve(8'h80, 24'h00FEDA, 4'h4, 0, 0, 9'h100);
        serve(8'h81, 24'h00FEDA, 4'h3, 0, 0, 9'h100);
        @(posedge MCLK) TP_BUSY <= 1'b1;
        serve(8'h80, 24'h00FEDA, 4'h3, 0, 0, 9'h003);
        // five groups served so far, last code busy, transport flagged busy
        rd(crq_pkg::REG_STAT, 32'h00050302);
        serve(8'h80, 24'h00EE00, 4'h3, 4, 8, 9'h000);
        @(posedge MCLK) TP_BUSY <= 1'b0;
        for (int j = 0; j < 2; j++) begin
            peer_u.send(8'h80, j ? 24'h00FED3 : 24'h00FECC, 4'h3);
            #1 check({ACK_VALID, ACK.ctrl, CLR_ACTIVE, CLR_PREV, TX_VALID},
                {1'b1, 8'h00, j[0], !j[0], 1'b0});
        end
        // a new own address moves specific requests; disabling drops them
        wr(crq_pkg::REG_CTRL, 32'h1A5);
        serve(8'hA5, 24'h00FECC, 4'h3, 0, 0, 9'h000);
        serve(8'h80, 24'h00FECC, 4'h3, 0, 0, 9'h100);
        wr(crq_pkg::REG_CTRL, 32'h0A5);
        serve(8'hA5, 24'h00FECC, 4'h3, 0, 0, 9'h100);
        rd(crq_pkg::REG_STAT, 32'h00090000);
        conclude();
    end
endmodule : test_crq_responder
